/* File: hdl/serdes_lane_defines.svh */
// Purpose: Offsets, field positions, reset values and counts for the serial lane control
// Assumes: 32-bit register words, byte addresses in steps of four
// Notes: Function
// Function
// - Lane runs 100M fiber, 1G, 2.5G, 5G rates
// - Lane active only while lane enable set
// - Lane held reset until both resets released
// - Equipment loopback feeds serializer into deserializer
// - Facility loopback feeds deserializer data to serializer
// - Recovered clock to lane or shared output
// - Auto squelch each clock output without PCS data
// - PI regulator, integral limit below proportional
// - Deadlock protection adds small frequency offset
// - Serializer phase align from its enable bit while lane runs
// - Level threshold taken from threshold field
`ifndef SERDES_LANE_DEFINES_SVH
`define SERDES_LANE_DEFINES_SVH
// Register byte addresses
`define OFS_COMMON      8'h00
`define OFS_MISC        8'h04
`define OFS_PLL         8'h08
`define OFS_DES         8'h0c
`define OFS_IB          8'h10
`define OFS_SER         8'h14
`define OFS_STATUS      8'h18
// Common fields
`define F_LANE_EN       0
`define F_SYSTEM_RESET_N_N     1
`define F_QUARTER_RATE_SELECT_SEL     2
`define F_HALF_RATE_SELECT_SEL     3
`define F_ELOOP         4
`define F_FLOOP         5
`define F_RECO_LANE     6
`define F_RECO_SHARED   7
`define F_SQ_LANE       8
`define F_SQ_SHARED     9
// Reset values
`define RST_COMMON      10'h000
`define RST_LANE_RESET  1'b1
`define RST_PLL         12'h000
`define RST_DES         10'h16d
`define RST_IB          8'h68
// Calibration lasts this many cycles per unit of calibration data, plus one cycle
`define CAL_STEP_CYCLES 8'h04
`define WORD_W          10
`endif

/* File: hdl/serdes_lane_pkg.sv */
// Purpose: Types shared by the serial lane control
// Assumes: Used together with serdes_lane_defines.svh
// Notes: Calibration sequencer states only
package serdes_lane_pkg;
	// Calibration sequencer states
	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_RUN,
		CAL_LOCKED
	} cal_state_t;
endpackage

/* File: hdl/six_gig_serial_lane.sv */
// Purpose: Configuration, loopback, recovered clock and phase loop control of one lane
// Assumes: Analog word interfaces on ref_clk_i; rec_clk_i arrives asynchronously
// Notes: Registers reached over a plain strobe port, read data one cycle later
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "serdes_lane_defines.svh"
module six_gig_serial_lane (
	// Clock and reset
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_n_i,
	// Register port
	input  wire logic [7:0]                reg_addr_i,
	input  wire logic [31:0]               reg_wdata_i,
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	output logic      [31:0]               reg_rdata_o,
	// Parallel side (PCS)
	input  wire logic [`WORD_W-1:0]        tx_word_i,
	input  wire logic                      pcs_data_valid_i,
	output logic      [`WORD_W-1:0]        rx_word_o,
	// Analog side words and phase detector
	input  wire logic [`WORD_W-1:0]        rx_line_word_i,
	input  wire logic                      phase_early_i,
	input  wire logic                      phase_late_i,
	output logic      [`WORD_W-1:0]        ser_word_o,
	output logic signed [7:0]              phase_step_o,
	output logic                           serializer_phase_align_o,
	// Recovered clock pins
	input  wire logic                      rec_clk_i,
	output logic                           reco_lane_o,
	output logic                           reco_shared_o,
	output logic                           reco_shared_oe_n_o,
	// Analog configuration
	output logic                           lane_active_o,
	output logic                           pll_calibration_enable_o,
	output logic      [7:0]                pll_calibration_data_o,
	output logic      [2:0]                pll_rotation_o,
	output logic                           quarter_rate_select_o,
	output logic                           half_rate_select_o,
	output logic      [3:0]                level_detect_threshold_o,
	output logic      [3:0]                input_buffer_mode_o
);
	import serdes_lane_pkg::*;

	// Software-visible configuration
	logic [9:0]        common_cfg;                   // Enables, rates, loopbacks, clock selects
	logic              lane_reset;                   // Per-lane reset, held at power-up
	logic [11:0]       pll_cfg;                      // Cal data, cal enable, rotation
	logic [9:0]        des_cfg;                      // Limit, time constant, bandwidth, deadlock
	logic [7:0]        ib_cfg;                       // Threshold, fiber, offset comp, termination
	logic              ser_cfg;                      // Phase align enable
	// Internal state
	cal_state_t        cal_state;                    // Calibration sequencer
	logic [15:0]       cal_count;                    // Calibration duration count
	logic              system_reset_n_n_q;                  // Previous system reset bit
	logic [`WORD_W-1:0] des_word;                    // Deserializer input word
	logic signed [7:0] integ;                        // Integrator value
	logic [7:0]        integ_div;                    // Integrator update divider
	logic [1:0]        rec_sync;                     // Recovered clock synchroniser

	// Decode of bus accesses
	wire wr_common = reg_wr_i && (reg_addr_i == `OFS_COMMON);
	wire wr_misc   = reg_wr_i && (reg_addr_i == `OFS_MISC);
	wire wr_pll    = reg_wr_i && (reg_addr_i == `OFS_PLL);
	wire wr_des    = reg_wr_i && (reg_addr_i == `OFS_DES);
	wire wr_ib     = reg_wr_i && (reg_addr_i == `OFS_IB);
	wire wr_ser    = reg_wr_i && (reg_addr_i == `OFS_SER);

	// Field views
	wire       system_reset_n_n   = common_cfg[`F_SYSTEM_RESET_N_N];
	wire       eloop_en    = common_cfg[`F_ELOOP];
	wire       floop_en    = common_cfg[`F_FLOOP];
	wire [2:0] integ_limit = des_cfg[2:0];
	wire [2:0] integ_tc    = des_cfg[5:3];
	wire [2:0] prop_bw     = des_cfg[8:6];
	wire       deadlock_en = des_cfg[9];

	// Lane runs only when enabled and both resets released
	wire lane_run = common_cfg[`F_LANE_EN] && system_reset_n_n && !lane_reset;

	// Proportional gain falls as bandwidth value rises
	wire signed [7:0] prop_gain = 8'sh40 >>> prop_bw;
	// Integral ceiling kept below proportional gain
	// Top limit code saturates so lim_raw never turns negative
	wire signed [7:0] lim_raw   = (integ_limit == 3'd7) ? 8'sh7f : (8'sh01 <<< integ_limit);
	wire signed [7:0] integ_max = (lim_raw < prop_gain) ? lim_raw : prop_gain - 8'sh01;
	// Integrator update enable every 2^(tc+1) cycles
	// Low tc+1 bits set; shift kept four bits wide so tc 7 gives a full mask
	wire [7:0] tc_mask = ~(8'hff << ({1'b0, integ_tc} + 4'h1));
	wire integ_tick = ((integ_div & tc_mask) == tc_mask);
	// Proportional term from phase detector
	wire signed [7:0] prop_term = phase_early_i ? -prop_gain :
	                              phase_late_i  ? prop_gain : 8'sh00;
	// Deadlock protection bias
	wire signed [7:0] bias = deadlock_en ? 8'sh01 : 8'sh00;

	// Recovered clock gating per output
	wire rec_clk_s = rec_sync[1];
	wire lane_ok   = lane_run && !(common_cfg[`F_SQ_LANE] && !pcs_data_valid_i);
	wire share_ok  = lane_run && !(common_cfg[`F_SQ_SHARED] && !pcs_data_valid_i);
	wire share_drv = lane_run && common_cfg[`F_RECO_SHARED];

	// Read data selection
	wire [31:0] status_word = {16'h0000, integ, 4'h0, 1'b0,
	                           cal_state == CAL_LOCKED, cal_state == CAL_RUN, lane_run};
	wire [31:0] rd_mux =
		(reg_addr_i == `OFS_COMMON) ? {22'h000000, common_cfg} :
		(reg_addr_i == `OFS_MISC)   ? {31'h00000000, lane_reset} :
		(reg_addr_i == `OFS_PLL)    ? {20'h00000, pll_cfg} :
		(reg_addr_i == `OFS_DES)    ? {22'h000000, des_cfg} :
		(reg_addr_i == `OFS_IB)     ? {24'h000000, ib_cfg} :
		(reg_addr_i == `OFS_SER)    ? {31'h00000000, ser_cfg} :
		(reg_addr_i == `OFS_STATUS) ? status_word : 32'h00000000;

	// Register writes
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			common_cfg <= `RST_COMMON;
			lane_reset <= `RST_LANE_RESET;
			pll_cfg    <= `RST_PLL;
			des_cfg    <= `RST_DES;
			ib_cfg     <= `RST_IB;
			ser_cfg    <= 1'b0;
		end else begin
			if (wr_common) common_cfg <= reg_wdata_i[9:0];
			if (wr_misc)   lane_reset <= reg_wdata_i[0];
			if (wr_pll)    pll_cfg    <= reg_wdata_i[11:0];
			if (wr_des)    des_cfg    <= reg_wdata_i[9:0];
			if (wr_ib)     ib_cfg     <= reg_wdata_i[7:0];
			if (wr_ser)    ser_cfg    <= reg_wdata_i[0];
		end
	end

	// Read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h00000000;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
		end
	end

	// Calibration sequencer: runs on release of system reset with cal enabled
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_state   <= CAL_IDLE;
			cal_count   <= 16'h0000;
			system_reset_n_n_q <= 1'b0;
		end else begin
			system_reset_n_n_q <= system_reset_n_n;
			case (cal_state)
				CAL_IDLE: begin
					// Release edge with enable starts calibration
					if (system_reset_n_n && !system_reset_n_n_q && pll_cfg[8]) begin
						cal_state <= CAL_RUN;
						cal_count <= 16'(pll_cfg[7:0]) * 16'(`CAL_STEP_CYCLES);
					end
				end
				CAL_RUN: begin
					// Reset or disable aborts the run
					if (!system_reset_n_n || !pll_cfg[8]) begin
						cal_state <= CAL_IDLE;
					end else if (cal_count == 16'h0000) begin
						cal_state <= CAL_LOCKED;
					end else begin
						cal_count <= cal_count - 16'h0001;
					end
				end
				CAL_LOCKED: begin
					if (!system_reset_n_n || !pll_cfg[8]) begin
						cal_state <= CAL_IDLE;
					end
				end
				default: begin
					cal_state <= CAL_IDLE;
				end
			endcase
		end
	end

	// Data paths with both loopbacks
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ser_word_o <= '0;
			des_word   <= '0;
			rx_word_o  <= '0;
		end else begin
			// Serializer fed from deserializer in facility loopback
			ser_word_o <= floop_en ? des_word : tx_word_i;
			// Deserializer fed from serializer in equipment loopback
			des_word   <= eloop_en ? ser_word_o : rx_line_word_i;
			// Nothing forwarded while reset or disabled
			rx_word_o  <= lane_run ? des_word : '0;
		end
	end

	// PI phase regulator
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			integ        <= 8'sh00;
			integ_div    <= 8'h00;
			phase_step_o <= 8'sh00;
		end else if (!lane_run) begin
			integ        <= 8'sh00;
			integ_div    <= 8'h00;
			phase_step_o <= 8'sh00;
		end else begin
			integ_div <= integ_div + 8'h01;
			// Integrator steps toward error, clamped to ceiling
			if (integ_tick && phase_late_i && integ < integ_max) begin
				integ <= integ + 8'sh01;
			end else if (integ_tick && phase_early_i && integ > -integ_max) begin
				integ <= integ - 8'sh01;
			end
			phase_step_o <= prop_term + integ + bias;
		end
	end

	// Recovered clock synchroniser
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rec_sync <= 2'b00;
		end else begin
			rec_sync <= {rec_sync[0], rec_clk_i};
		end
	end

	// Recovered clock outputs, quiet under reset or squelch
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reco_lane_o        <= 1'b0;
			reco_shared_o      <= 1'b0;
			reco_shared_oe_n_o <= 1'b1;
		end else begin
			reco_lane_o        <= rec_clk_s && common_cfg[`F_RECO_LANE] && lane_ok;
			reco_shared_o      <= rec_clk_s && share_drv && share_ok;
			reco_shared_oe_n_o <= !share_drv;
		end
	end

	// Analog configuration outputs
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lane_active_o            <= 1'b0;
			pll_calibration_enable_o <= 1'b0;
			pll_calibration_data_o   <= 8'h00;
			pll_rotation_o           <= 3'h0;
			quarter_rate_select_o    <= 1'b0;
			half_rate_select_o       <= 1'b0;
			level_detect_threshold_o <= 4'h0;
			input_buffer_mode_o      <= 4'h0;
			serializer_phase_align_o <= 1'b0;
		end else begin
			lane_active_o            <= lane_run;
			pll_calibration_enable_o <= cal_state == CAL_RUN;
			pll_calibration_data_o   <= pll_cfg[7:0];
			pll_rotation_o           <= pll_cfg[11:9];
			quarter_rate_select_o    <= common_cfg[`F_QUARTER_RATE_SELECT_SEL];
			half_rate_select_o       <= common_cfg[`F_HALF_RATE_SELECT_SEL];
			level_detect_threshold_o <= ib_cfg[3:0];
			// Fiber, offset ac, offset dc, termination
			input_buffer_mode_o      <= ib_cfg[7:4];
			serializer_phase_align_o <= ser_cfg && lane_run;
		end
	end
endmodule

/* File: testbench/serdes_far_end.sv */
// Purpose: Far-end transceiver seen through the analog word side
// Assumes: One word per reference clock
// Notes: Recovered clock runs free; detector early idle, late on request
`timescale 1ns/1ps
module serdes_far_end (
	// Clock
	input  wire logic  ref_clk_i,
	// Bench control of the phase detector
	input  wire logic  late_i,
	// Line side
	output logic [9:0] rx_line_word_o,
	output logic       phase_early_o,
	output logic       phase_late_o,
	output logic       rec_clk_o
);
	// Known start values
	initial begin
		rx_line_word_o = 10'h155;
		phase_early_o = 1'b0;
		rec_clk_o = 1'b0;
	end
	// Detector reports late sampling on request
	assign phase_late_o = late_i;
	// Word changes every cycle so data under 20 cycles stale never matches
	always @(posedge ref_clk_i) begin
		rx_line_word_o <= {rx_line_word_o[8:0], ~rx_line_word_o[9]};
	end
	// Unrelated in phase to the reference
	always #37 rec_clk_o = ~rec_clk_o;
endmodule

/* File: testbench/serdes_lane_chk.sv */
// Purpose: Port-level checks of the serial lane control
// Assumes: Bound to six_gig_serial_lane, one clock domain
// Notes: Copies of fields appear two edges after the write
`timescale 1ns/1ps
`include "serdes_lane_defines.svh"
module serdes_lane_chk (
	// Clock and reset
	input logic                ref_clk_i,
	input logic                rst_n_i,
	// Register port
	input logic [7:0]          reg_addr_i,
	input logic [31:0]         reg_wdata_i,
	input logic                reg_wr_i,
	input logic                reg_rd_i,
	input logic [31:0]         reg_rdata_o,
	// Lane outputs
	input logic [`WORD_W-1:0]  rx_word_o,
	input logic                serializer_phase_align_o,
	input logic                reco_lane_o,
	input logic                reco_shared_o,
	input logic                reco_shared_oe_n_o,
	input logic                lane_active_o,
	input logic                pll_calibration_enable_o,
	input logic [7:0]          pll_calibration_data_o,
	input logic                quarter_rate_select_o,
	input logic                half_rate_select_o,
	input logic [3:0]          level_detect_threshold_o,
	input logic [3:0]          input_buffer_mode_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [9:0]                cal_len;  // High cycles so far in this run
	// Length of the running calibration
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_len <= 10'h000;
		end else if (pll_calibration_enable_o) begin
			cal_len <= cal_len + 10'h001;
		end else begin
			cal_len <= 10'h000;
		end
	end
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside its slot");
	a_rate_copy: assert property (reg_wr_i && reg_addr_i == `OFS_COMMON |-> ##2
		{half_rate_select_o, quarter_rate_select_o} == $past(reg_wdata_i[3:2], 2))
		else $error("rate select not copied");
	a_ib_copy: assert property (reg_wr_i && reg_addr_i == `OFS_IB |-> ##2
		{input_buffer_mode_o, level_detect_threshold_o} == $past(reg_wdata_i[7:0], 2))
		else $error("input buffer settings not copied");
	a_rx_quiet: assert property ((!lane_active_o) [*3] |-> rx_word_o == '0)
		else $error("word forwarded while lane idle");
	a_reco_quiet: assert property ((!lane_active_o) [*4] |-> !reco_lane_o && !reco_shared_o)
		else $error("recovered clock while lane idle");
	a_pin_release: assert property ((!lane_active_o) [*4] |-> reco_shared_oe_n_o)
		else $error("shared pin driven while lane idle");
	a_shared_drive: assert property (reco_shared_o |-> !reco_shared_oe_n_o)
		else $error("shared clock without pin drive");
	a_align_run: assert property (serializer_phase_align_o |-> lane_active_o)
		else $error("phase align while lane idle");
	a_cal_len: assert property (pll_calibration_enable_o |-> cal_len <= {pll_calibration_data_o, 2'b00})
		else $error("calibration runs too long");
endmodule

/* File: testbench/six_gig_serial_lane_tb.sv */
// Purpose: Self-checking bench for the serial lane control
// Assumes: Strobe register port, read data one cycle after the strobe
// Notes: Checker bound at the foot
`timescale 1ns/1ps
`include "serdes_lane_defines.svh"
`define CHK(nm, exp, got) \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("ERROR %s expected %0h seen %0h", nm, exp, got); \
	end
module six_gig_serial_lane_tb;
	import serdes_lane_pkg::*;
	logic              ref_clk_i = 1'b0;      // Bench clock
	logic              rst_n_i = 1'b0;        // Reset, active low
	logic [7:0]        reg_addr_i = 8'h00;    // Register port
	logic [31:0]       reg_wdata_i = 32'h0;
	logic              reg_wr_i = 1'b0;
	logic              reg_rd_i = 1'b0;
	logic [31:0]       reg_rdata_o;
	logic [9:0]        tx_word_i = 10'h000;   // PCS side
	logic              pcs_data_valid_i = 1'b0;
	logic              late_drv = 1'b0;       // Far-end late indication
	logic [9:0]        rx_word_o, rx_line_word_i, ser_word_o, lw;
	logic              phase_early_i, phase_late_i, rec_clk_i;
	logic signed [7:0] phase_step_o;
	logic              serializer_phase_align_o, reco_lane_o, reco_shared_o, reco_shared_oe_n_o;
	logic              lane_active_o, pll_calibration_enable_o, quarter_rate_select_o, half_rate_select_o;
	logic [7:0]        pll_calibration_data_o;
	logic [2:0]        pll_rotation_o;
	logic [3:0]        level_detect_threshold_o, input_buffer_mode_o;
	logic [31:0]       rd;
	int                n_mismatch, cmp_count, i, k, w, nl, ns;
	// Reset values, then per rate: PLL word, rate bits, run length, outputs
	logic [31:0] rst_tab [8] = '{32'h0, 32'h1, 32'h0, 32'h16d, 32'h68, 32'h0, 32'h0, 32'h0};
	logic [31:0] pll_tab [2] = '{32'h43c, 32'ha30};
	logic [31:0] com_tab [2] = '{32'h4, 32'h8};
	logic [31:0] sq_tab [2] = '{32'h1cb, 32'h2cb};
	int          len_tab [2] = '{241, 193};
	logic [12:0] out_tab [2] = '{13'h78a, 13'h615};
	initial forever #10 ref_clk_i = ~ref_clk_i;
	six_gig_serial_lane uut (.*);
	serdes_far_end far (
		.ref_clk_i      (ref_clk_i),
		.late_i         (late_drv),
		.rx_line_word_o (rx_line_word_i),
		.phase_early_o  (phase_early_i),
		.phase_late_o   (phase_late_i),
		.rec_clk_o      (rec_clk_i)
	);
	// Wait edges, then settle
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
		tick(1);
	endtask
	// One-cycle register read
	task automatic rdr(input logic [7:0] a);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		rd = reg_rdata_o;
		tick(1);
	endtask
	// Count high cycles of both clock pins
	task automatic watch();
		nl = 0;
		ns = 0;
		repeat (40) begin
			tick(1);
			nl += reco_lane_o;
			ns += reco_shared_o;
		end
	endtask
	// Verdict and end of run
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		tick(5);
		rst_n_i <= 1'b1;
		tick(1);
		for (i = 0; i < 8; i++) begin
			rdr(8'(i * 4));
			`CHK("reset value", rst_tab[i], rd)
		end
		for (k = 0; k < 2; k++) begin
			wr(`OFS_PLL, pll_tab[k]);
			wr(`OFS_COMMON, com_tab[k]);
			wr(`OFS_PLL, pll_tab[k] | 32'h100);
			wr(`OFS_COMMON, com_tab[k] | 32'h2);
			i = 0;
			for (w = 0; w < 400 && !(i > 0 && !pll_calibration_enable_o); w++) begin
				i += pll_calibration_enable_o;
				tick(1);
			end
			if (w >= 400) begin
				n_mismatch++;
				end_sim();
			end
			`CHK("calibration length", len_tab[k], i)
			rdr(`OFS_STATUS);
			`CHK("locked", 1'b1, rd[2])
			`CHK("rate outputs", out_tab[k], {pll_calibration_data_o, pll_rotation_o, quarter_rate_select_o, half_rate_select_o})
		end
		`CHK("active without enable", 1'b0, lane_active_o)
		wr(`OFS_COMMON, 32'h00b);
		`CHK("active under lane reset", 1'b0, lane_active_o)
		wr(`OFS_MISC, 32'h0);
		`CHK("active", 1'b1, lane_active_o)
		tx_word_i <= 10'h2a5;
		lw = rx_line_word_i;
		tick(1);
		`CHK("serializer word", 10'h2a5, ser_word_o)
		tick(1);
		`CHK("received word", lw, rx_word_o)
		wr(`OFS_COMMON, 32'h01b);
		tx_word_i <= 10'h1c3;
		tick(3);
		`CHK("looped word", 10'h1c3, rx_word_o)
		`CHK("visible output", 10'h1c3, ser_word_o)
		wr(`OFS_COMMON, 32'h02b);
		wr(`OFS_SER, 32'h1);
		lw = rx_line_word_i;
		tick(2);
		`CHK("returned word", lw, ser_word_o)
		`CHK("phase align", 1'b1, serializer_phase_align_o)
		for (k = 0; k < 2; k++) begin
			wr(`OFS_COMMON, sq_tab[k]);
			tick(4);
			watch();
			`CHK("lane clock", k[0], nl > 0)
			`CHK("shared clock", !k[0], ns > 0)
		end
		pcs_data_valid_i <= 1'b1;
		watch();
		`CHK("both clocks", 1'b1, nl > 0 && ns > 0)
		`CHK("shared pin driven", 1'b0, reco_shared_oe_n_o)
		`CHK("phase step idle", 8'sh00, phase_step_o)
		wr(`OFS_DES, 32'h36d);
		tick(1);
		`CHK("deadlock offset", 8'sh01, phase_step_o)
		late_drv <= 1'b1;
		tick(70);
		`CHK("regulator step", 8'sh04, phase_step_o)
		late_drv <= 1'b0;
		tick(1);
		wr(`OFS_IB, 32'h9a);
		tick(1);
		`CHK("buffer mode", 8'h9a, {input_buffer_mode_o, level_detect_threshold_o})
		wr(`OFS_MISC, 32'h1);
		tick(4);
		`CHK("held lane", 13'h0, {lane_active_o, rx_word_o, reco_lane_o, reco_shared_o})
		end_sim();
	end
endmodule
bind six_gig_serial_lane serdes_lane_chk chk (.*);
